//--- include/rti_pkg.sv
// Purpose: shared constants and types for the real-time clock timer and interrupt block
// Assumes: register port addresses are 8-bit, data is 8-bit
// Notes:   field layout of the interrupt/flag register mirrors the bit order of the struct
package rti_pkg;

	// register addresses
	localparam logic [7:0] RTI_ADDR_IRQ_FLAG_CTRL = 8'h01;
	localparam logic [7:0] RTI_ADDR_CD_VALUE      = 8'h0A;
	localparam logic [7:0] RTI_ADDR_CD_CTRL       = 8'h0E;

	// field positions in the interrupt/flag register
	localparam int RTI_BIT_MIN_EN    = 7;
	localparam int RTI_BIT_SEC_EN    = 6;
	localparam int RTI_BIT_TICK_FLAG = 5;
	localparam int RTI_BIT_PULSE_SEL = 4;
	localparam int RTI_BIT_CD_FLAG   = 2;
	localparam int RTI_BIT_CD_IRQ_EN = 0;

	// field positions in the countdown control register
	localparam int RTI_BIT_CD_RUN    = 7;
	localparam int RTI_CD_RSVD_HI    = 6;
	localparam int RTI_CD_RSVD_LO    = 2;

	// countdown source clock selections
	localparam logic [1:0] RTI_SRC_4096HZ = 2'h0;
	localparam logic [1:0] RTI_SRC_64HZ   = 2'h1;
	localparam logic [1:0] RTI_SRC_1HZ    = 2'h2;
	localparam logic [1:0] RTI_SRC_MINUTE = 2'h3;

	// reset values and countdown count constants
	localparam logic [7:0] RTI_IRQ_FLAG_CTRL_RST = 8'h00;
	localparam logic [7:0] RTI_CD_VALUE_RST      = 8'h00;
	localparam logic [1:0] RTI_CD_SRC_RST        = 2'h3;
	localparam logic [7:0] RTI_CD_CNT_ONE        = 8'h01;
	localparam logic [7:0] RTI_CD_CNT_ZERO       = 8'h00;

	// interrupt/flag register image, bit 7 first
	typedef struct packed {
		logic sixty_second_tick_en;
		logic one_second_tick_en;
		logic tick_flag;
		logic irq_pulse_select;
		logic alarm_flag;
		logic countdown_flag;
		logic alarm_irq_en;
		logic countdown_irq_en;
	} rti_irq_ctrl_t;

	// register write port
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rti_reg_req_t;

endpackage

//--- src/rti_timer.sv
// Purpose: countdown timer, second/minute tick interrupts and interrupt pin control
// Assumes: tick inputs are one-cycle pulses from the prescaler on clk_i
// Notes:   alarm source only enters the wired-OR; its flag logic lives elsewhere
`timescale 1ns/1ps

// Operation
// R1: bit 7 of interrupt/flag register enables the once-per-minute source.
// R2: bit 6 enables the once-per-second source, independent of minute.
// R3: bit 5 tick flag sets on a periodic event, holds interrupt until cleared.
// R4: bit 4 chooses level (0) or one pulse per event (1) interrupt.
// R5: bit 2 countdown flag sets on countdown event, holds interrupt until cleared.
// R6: bit 0 gates the countdown flag onto the interrupt output.
// R7: timer control bit 7 runs the countdown when set, halts when clear.
// R8: timer control bits 1:0 pick 4096 Hz, 64 Hz, 1 Hz or per-minute source.
// R9: timer control bits 6:2 are reserved and read zero.
// R10: countdown value is an 8-bit n; a period is n source ticks.
// R11: periodic interrupt per minute, per second, or none, by enables.
// R12: tick flag sets on minute increments or second increments as enabled; here minute increments are ignored while bit 6 is set.
// R13: pulses are emitted even when the tick flag stays set.
// R14: flag writes are ANDed: writing 1 keeps a flag, writing 0 clears it.
// R15: count down from n; at 1 set flag and reload; n of 0 stops.
// R16: periodic pulse lasts one 64 Hz period, ends early when flag cleared.
// R17: interrupt pin is active low, a wired OR of all sources.
// R18: level mode asserts on enabled tick flag or gated countdown flag.
module rti_timer
	import rti_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       tick_4096hz_i,
	input  wire logic       tick_64hz_i,
	input  wire logic       tick_1hz_i,
	input  wire logic       tick_minute_i,
	input  wire logic       alarm_irq_i,
	input  wire logic       irq_pin_i,
	output logic            irq_pin_o,
	output logic            irq_pin_oe_o,
	output logic            int_n_o
);

	rti_reg_req_t  req;
	rti_irq_ctrl_t ctrl_ff, nxt_ctrl;
	logic [7:0]    cd_value_ff, nxt_cd_value;
	logic [7:0]    cd_cnt_ff, nxt_cd_cnt;
	logic          cd_run_ff, nxt_cd_run;
	logic [1:0]    cd_src_ff, nxt_cd_src;
	logic          tick_pulse_ff, nxt_tick_pulse;
	logic          cd_pulse_ff, nxt_cd_pulse;
	logic          int_n_ff, nxt_int_n;
	logic [7:0]    rdata_ff, nxt_rdata;
	logic          wr_ctrl, wr_cd_value, wr_cd_ctrl;
	logic          periodic_evt, cd_src_tick, cd_evt;
	logic          periodic_src, cd_irq_src, irq_active;
	logic          pin_unused;

	// address decode of the register write port
	assign req         = '{wr: reg_wr_i, addr: reg_addr_i, wdata: reg_wdata_i};
	assign wr_ctrl     = req.wr && (req.addr == RTI_ADDR_IRQ_FLAG_CTRL);
	assign wr_cd_value = req.wr && (req.addr == RTI_ADDR_CD_VALUE);
	assign wr_cd_ctrl  = req.wr && (req.addr == RTI_ADDR_CD_CTRL);
	assign pin_unused  = irq_pin_i; // pin level is not needed inside

	// periodic event: seconds win over minutes when both are enabled
	always_comb begin
		if (ctrl_ff.one_second_tick_en) begin
			periodic_evt = tick_1hz_i; // [R2] [R11] [R12]
		end else begin
			periodic_evt = ctrl_ff.sixty_second_tick_en && tick_minute_i; // [R1] [R11] [R12]
		end
	end

	// countdown source clock mux
	always_comb begin
		case (cd_src_ff) // [R8]
			RTI_SRC_4096HZ: cd_src_tick = tick_4096hz_i;
			RTI_SRC_64HZ:   cd_src_tick = tick_64hz_i;
			RTI_SRC_1HZ:    cd_src_tick = tick_1hz_i;
			default:        cd_src_tick = tick_minute_i;
		endcase
	end

	// countdown end of period; a zero reload value keeps the timer still
	assign cd_evt = cd_run_ff && cd_src_tick && (cd_value_ff != RTI_CD_CNT_ZERO)
		&& (cd_cnt_ff <= RTI_CD_CNT_ONE) && !wr_cd_value; // [R7] [R15]

	// control register and flags: set wins over the AND-clear of a write
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr_ctrl) begin
			nxt_ctrl.sixty_second_tick_en = req.wdata[RTI_BIT_MIN_EN]; // [R1]
			nxt_ctrl.one_second_tick_en   = req.wdata[RTI_BIT_SEC_EN]; // [R2]
			nxt_ctrl.irq_pulse_select     = req.wdata[RTI_BIT_PULSE_SEL]; // [R4]
			nxt_ctrl.countdown_irq_en     = req.wdata[RTI_BIT_CD_IRQ_EN]; // [R6]
			nxt_ctrl.tick_flag      = ctrl_ff.tick_flag && req.wdata[RTI_BIT_TICK_FLAG]; // [R14]
			nxt_ctrl.countdown_flag = ctrl_ff.countdown_flag && req.wdata[RTI_BIT_CD_FLAG]; // [R14]
		end
		nxt_ctrl.tick_flag      = nxt_ctrl.tick_flag || periodic_evt; // [R3] [R12]
		nxt_ctrl.countdown_flag = nxt_ctrl.countdown_flag || cd_evt; // [R5]
		nxt_ctrl.alarm_flag     = 1'b0;
		nxt_ctrl.alarm_irq_en   = 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			ctrl_ff <= rti_irq_ctrl_t'(RTI_IRQ_FLAG_CTRL_RST);
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// countdown value, counter and timer control
	always_comb begin
		nxt_cd_value = cd_value_ff;
		nxt_cd_cnt   = cd_cnt_ff;
		nxt_cd_run   = cd_run_ff;
		nxt_cd_src   = cd_src_ff;
		if (wr_cd_ctrl) begin
			nxt_cd_run = req.wdata[RTI_BIT_CD_RUN]; // [R7]
			nxt_cd_src = req.wdata[1:0]; // [R8]
		end
		if (wr_cd_value) begin
			nxt_cd_value = req.wdata; // [R10] new n takes effect at once
			nxt_cd_cnt   = req.wdata;
		end else if (cd_evt) begin
			nxt_cd_cnt = cd_value_ff; // [R15] reload for next period
		end else if (cd_run_ff && cd_src_tick && (cd_cnt_ff != RTI_CD_CNT_ZERO)) begin
			nxt_cd_cnt = cd_cnt_ff - RTI_CD_CNT_ONE; // [R10] [R15]
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			cd_value_ff <= RTI_CD_VALUE_RST;
			cd_cnt_ff   <= RTI_CD_VALUE_RST;
			cd_run_ff   <= 1'b0;
			cd_src_ff   <= RTI_CD_SRC_RST;
		end else begin
			cd_value_ff <= nxt_cd_value;
			cd_cnt_ff   <= nxt_cd_cnt;
			cd_run_ff   <= nxt_cd_run;
			cd_src_ff   <= nxt_cd_src;
		end
	end

	// pulse generators: start on event, end at next 64 Hz tick or flag clear
	always_comb begin
		nxt_tick_pulse = tick_pulse_ff;
		nxt_cd_pulse   = cd_pulse_ff;
		if (tick_64hz_i || !nxt_ctrl.tick_flag) begin
			nxt_tick_pulse = 1'b0; // [R16]
		end
		if (tick_64hz_i || !nxt_ctrl.countdown_flag) begin
			nxt_cd_pulse = 1'b0;
		end
		if (periodic_evt) begin
			nxt_tick_pulse = 1'b1; // [R13] regardless of old flag
		end
		if (cd_evt) begin
			nxt_cd_pulse = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			tick_pulse_ff <= 1'b0;
			cd_pulse_ff   <= 1'b0;
		end else begin
			tick_pulse_ff <= nxt_tick_pulse;
			cd_pulse_ff   <= nxt_cd_pulse;
		end
	end

	// interrupt source combine, active low wired OR
	always_comb begin
		if (ctrl_ff.irq_pulse_select) begin
			periodic_src = tick_pulse_ff; // [R4]
			cd_irq_src   = cd_pulse_ff;
		end else begin
			periodic_src = ctrl_ff.tick_flag
				&& (ctrl_ff.sixty_second_tick_en || ctrl_ff.one_second_tick_en); // [R18]
			cd_irq_src   = ctrl_ff.countdown_flag; // [R5]
		end
		irq_active = periodic_src || (ctrl_ff.countdown_irq_en && cd_irq_src)
			|| alarm_irq_i; // [R6] [R17]
		nxt_int_n  = !irq_active; // [R17]
	end

	// read data mux, reserved bits read zero
	always_comb begin
		case (req.addr)
			RTI_ADDR_IRQ_FLAG_CTRL: nxt_rdata = ctrl_ff;
			RTI_ADDR_CD_VALUE:      nxt_rdata = cd_cnt_ff; // current count, not n
			RTI_ADDR_CD_CTRL:       nxt_rdata = {cd_run_ff, 5'h00, cd_src_ff}; // [R9]
			default:                nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			int_n_ff <= 1'b1;
			rdata_ff <= 8'h00;
		end else begin
			int_n_ff <= nxt_int_n;
			rdata_ff <= nxt_rdata;
		end
	end

	// open-drain pin: drive low only while active
	assign int_n_o      = int_n_ff;
	assign irq_pin_o    = 1'b0;
	assign irq_pin_oe_o = !int_n_ff;
	assign reg_rdata_o  = rdata_ff;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	property p_min_only;
		ctrl_ff.sixty_second_tick_en && !ctrl_ff.one_second_tick_en && tick_minute_i
			|=> ctrl_ff.tick_flag;
	endproperty
	a_min_only: assert property (p_min_only) else $error("minute tick did not set flag"); // [R1]

	property p_sec;
		ctrl_ff.one_second_tick_en && tick_1hz_i |=> ctrl_ff.tick_flag;
	endproperty
	a_sec: assert property (p_sec) else $error("second tick did not set flag"); // [R2]

	property p_no_src;
		!ctrl_ff.sixty_second_tick_en && !ctrl_ff.one_second_tick_en && !ctrl_ff.tick_flag
			|=> !ctrl_ff.tick_flag;
	endproperty
	a_no_src: assert property (p_no_src) else $error("flag set with sources off"); // [R12]

	property p_flag_hold;
		ctrl_ff.tick_flag && !wr_ctrl |=> ctrl_ff.tick_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("tick flag lost"); // [R3]

	property p_and_clear;
		wr_ctrl && !req.wdata[RTI_BIT_CD_FLAG] && !cd_evt |=> !ctrl_ff.countdown_flag;
	endproperty
	a_and_clear: assert property (p_and_clear) else $error("flag not cleared"); // [R14]

	property p_reload;
		cd_evt |=> ctrl_ff.countdown_flag && (cd_cnt_ff == $past(cd_value_ff));
	endproperty
	a_reload: assert property (p_reload) else $error("no reload at end"); // [R15]

	property p_halt;
		(!cd_run_ff || cd_value_ff == RTI_CD_CNT_ZERO) && !wr_cd_value && !wr_cd_ctrl
			|=> $stable(cd_cnt_ff);
	endproperty
	a_halt: assert property (p_halt) else $error("counter moved while halted"); // [R7]

	property p_level;
		!ctrl_ff.irq_pulse_select && ctrl_ff.countdown_flag && ctrl_ff.countdown_irq_en
			|=> !int_n_o && irq_pin_oe_o;
	endproperty
	a_level: assert property (p_level) else $error("level interrupt missing"); // [R18]

	property p_pulse;
		ctrl_ff.irq_pulse_select && periodic_evt |=> tick_pulse_ff ##1 !int_n_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("periodic pulse missing"); // [R13]

	property p_rsvd;
		req.addr == RTI_ADDR_CD_CTRL |=> reg_rdata_o[RTI_CD_RSVD_HI:RTI_CD_RSVD_LO] == 5'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero"); // [R9]

endmodule

//--- verif/tb.sv
// Purpose: self-checking bench for the timer and interrupt block
// Assumes: prescaler ticks are one-cycle pulses driven by the bench on clk_i
// Notes:   reads return data one cycle after the address is presented
`timescale 1ns/1ps
module tb
	import rti_pkg::*;
;
	logic       clk_i;
	logic       reset_n_i;
	logic       reg_wr_i;
	logic [7:0] reg_addr_i;
	logic [7:0] reg_wdata_i;
	logic [7:0] reg_rdata_o;
	logic [3:0] tk;
	logic       alarm_irq_i;
	logic       irq_pin_o;
	logic       irq_pin_oe_o;
	logic       int_n_o;
	logic [7:0] en;
	logic       f;
	int         n_fail;
	int         check_count;

	// device under test; tk bits follow the source select encoding
	rti_timer dut (
		.clk_i         (clk_i),
		.reset_n_i     (reset_n_i),
		.reg_wr_i      (reg_wr_i),
		.reg_addr_i    (reg_addr_i),
		.reg_wdata_i   (reg_wdata_i),
		.reg_rdata_o   (reg_rdata_o),
		.tick_4096hz_i (tk[0]),
		.tick_64hz_i   (tk[1]),
		.tick_1hz_i    (tk[2]),
		.tick_minute_i (tk[3]),
		.alarm_irq_i   (alarm_irq_i),
		.irq_pin_i     (1'b0),
		.irq_pin_o     (irq_pin_o),
		.irq_pin_oe_o  (irq_pin_oe_o),
		.int_n_o       (int_n_o)
	);

	// 50 MHz clock
	always #10 clk_i = ~clk_i;

	// compare and count
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i    <= 1'b0;
	endtask

	// present address, sample registered data one cycle later
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		reg_addr_i <= a;
		@(posedge clk_i);
		#1;
		check("rdata", reg_rdata_o, exp);
	endtask

	// one-cycle prescaler tick
	task automatic tick(input int i);
		@(posedge clk_i);
		tk[i] <= 1'b1;
		@(posedge clk_i);
		tk[i] <= 1'b0;
	endtask

	// interrupt level and pin enable one cycle on
	task automatic chk_int(input logic e);
		@(posedge clk_i);
		#1;
		check("int_n", {7'h00, int_n_o}, {7'h00, e});
		check("pin_oe", {7'h00, irq_pin_oe_o}, {7'h00, ~e});
	endtask

	// verdict and end of run
	task automatic print_verdict();
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// watchdog against a hang
	initial begin
		#100000;
		n_fail++;
		print_verdict();
	end

	// main sequence
	initial begin
		clk_i = 1'b0;
		reset_n_i = 1'b0;
		reg_wr_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		tk = 4'h0;
		alarm_irq_i = 1'b0;
		n_fail = 0;
		check_count = 0;
		repeat (20) @(posedge clk_i);
		reset_n_i <= 1'b1;
		// reset values, unmapped address and reserved bits
		rd(RTI_ADDR_IRQ_FLAG_CTRL, 8'h00);
		rd(RTI_ADDR_CD_VALUE, 8'h00);
		rd(RTI_ADDR_CD_CTRL, 8'h03);
		rd(8'h05, 8'h00);
		chk_int(1'b1);
		wr(RTI_ADDR_CD_CTRL, 8'hFF);
		rd(RTI_ADDR_CD_CTRL, 8'h83);
		wr(RTI_ADDR_IRQ_FLAG_CTRL, 8'hFF);
		rd(RTI_ADDR_IRQ_FLAG_CTRL, 8'hD1);
		wr(RTI_ADDR_IRQ_FLAG_CTRL, 8'h00);
		// countdown through every source, gate and flag writes
		for (int s = 0; s < 4; s++) begin
			wr(RTI_ADDR_CD_CTRL, 8'h80 | 8'(s));
			wr(RTI_ADDR_CD_VALUE, 8'h03);
			tick((s + 1) % 4);
			rd(RTI_ADDR_CD_VALUE, 8'h03);
			tick(s);
			tick(s);
			rd(RTI_ADDR_CD_VALUE, 8'h01);
			tick(s);
			rd(RTI_ADDR_CD_VALUE, 8'h03);
			rd(RTI_ADDR_IRQ_FLAG_CTRL, 8'h04);
			chk_int(1'b1);
			wr(RTI_ADDR_IRQ_FLAG_CTRL, 8'h05);
			chk_int(1'b0);
			rd(RTI_ADDR_IRQ_FLAG_CTRL, 8'h05);
			wr(RTI_ADDR_IRQ_FLAG_CTRL, 8'h01);
			chk_int(1'b1);
			wr(RTI_ADDR_IRQ_FLAG_CTRL, 8'h00);
		end
		// halted timer and zero value
		wr(RTI_ADDR_CD_CTRL, 8'h00);
		tick(0);
		rd(RTI_ADDR_CD_VALUE, 8'h03);
		wr(RTI_ADDR_CD_CTRL, 8'h80);
		wr(RTI_ADDR_CD_VALUE, 8'h00);
		tick(0);
		tick(0);
		rd(RTI_ADDR_CD_VALUE, 8'h00);
		rd(RTI_ADDR_IRQ_FLAG_CTRL, 8'h00);
		// periodic sources in level mode, every enable pair
		for (int k = 0; k < 4; k++) begin
			en = {k[1], k[0], 6'h00};
			wr(RTI_ADDR_IRQ_FLAG_CTRL, en);
			tick(3);
			f = en[7] & ~en[6];
			rd(RTI_ADDR_IRQ_FLAG_CTRL, en | {2'h0, f, 5'h00});
			chk_int(~f);
			wr(RTI_ADDR_IRQ_FLAG_CTRL, en);
			tick(2);
			f = en[6];
			rd(RTI_ADDR_IRQ_FLAG_CTRL, en | {2'h0, f, 5'h00});
			chk_int(~f);
			wr(RTI_ADDR_IRQ_FLAG_CTRL, 8'h00);
		end
		// pulse mode: end on 64 Hz tick, repeat with flag set, early end on clear
		wr(RTI_ADDR_IRQ_FLAG_CTRL, 8'h50);
		tick(2);
		chk_int(1'b0);
		tick(1);
		chk_int(1'b1);
		rd(RTI_ADDR_IRQ_FLAG_CTRL, 8'h70);
		tick(2);
		chk_int(1'b0);
		wr(RTI_ADDR_IRQ_FLAG_CTRL, 8'h50);
		chk_int(1'b1);
		// countdown pulse: gated event starts it, next 64 Hz tick ends it
		wr(RTI_ADDR_IRQ_FLAG_CTRL, 8'h15);
		wr(RTI_ADDR_CD_VALUE, 8'h01);
		tick(0);
		chk_int(1'b0);
		tick(1);
		chk_int(1'b1);
		rd(RTI_ADDR_IRQ_FLAG_CTRL, 8'h15);
		wr(RTI_ADDR_IRQ_FLAG_CTRL, 8'h00);
		// alarm request shares the pin
		@(posedge clk_i);
		alarm_irq_i <= 1'b1;
		@(posedge clk_i);
		chk_int(1'b0);
		check("pin", {7'h00, irq_pin_o}, 8'h00);
		@(posedge clk_i);
		alarm_irq_i <= 1'b0;
		chk_int(1'b1);
		print_verdict();
	end
endmodule
